// >>> rx_cdr_lock_and_clocking.sv
// Receive clocking and clock-recovery lock control for one channel.
// Assumes recovered, transmit and core clocks arrive as sys_clk enables.
`timescale 1ns/10ps
`default_nettype none
module rx_cdr_lock_and_clocking
  import rx_clk_pkg::*;
#(
  parameter int DEPTH     = FIFO_DEPTH,
  parameter int WIDTH     = FIFO_WIDTH,
  parameter int WORD_BITS = 10
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             recov_clk_en,
  input  wire logic             tx_clk_en,
  input  wire logic             core_clk_en,
  input  wire logic             fabric_rd_clk_en,
  input  wire logic             fabric_rd_clk_used,
  input  wire logic             bonded,
  input  wire logic             byte_deser_on,
  input  wire logic             rate_match_on,
  input  wire logic [WIDTH-1:0] rx_word,
  input  wire logic             force_data_lock,
  input  wire logic             force_ref_lock,
  input  wire logic             ref_freq_near,
  input  wire logic             manual_align,
  input  wire logic             aligner_slip,
  input  wire logic             above_threshold,
  input  wire logic             pcie_mode,
  input  wire logic             basic_8b10b_mode,
  input  wire logic             gigabit_ethernet_mode,
  output logic                  pcs_clk_en_q,
  output logic                  fifo_wr_en_q,
  output logic                  rx_clk_out_q,
  output logic                  recov_clk_tap_q,
  output logic                  tx_clk_out_q,
  output logic [WIDTH-1:0]      rx_data_q,
  output logic                  rx_data_valid_q,
  output logic                  fifo_error_q,
  output logic                  data_lock_q,
  output logic [4:0]            slip_count_out,
  output logic                  signal_present_q
);
  phase_fifo_if #(.WIDTH(WIDTH)) fifo_bus ();

  phase_fifo #(.DEPTH(DEPTH), .WIDTH(WIDTH)) fifo_inst (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .port_if (fifo_bus.fifo)
  );

  //////////////////////////////////////////////////////////////////////////
  // Clock enable selection
  logic half_q;
  logic wr_strobe;
  logic rd_strobe;
  logic err_sample;

  // Deserializer on: write every second recovered edge
  assign wr_strobe  = recov_clk_en && (!byte_deser_on || half_q);
  // Fabric clock reads when supplied, else recovered rate
  assign rd_strobe  = fabric_rd_clk_used ? fabric_rd_clk_en
                                         : recov_clk_en;
  // Error timed by core clock when bonded, tx clock otherwise
  assign err_sample = bonded ? core_clk_en : tx_clk_en;

  assign fifo_bus.wr_en   = wr_strobe;
  assign fifo_bus.wr_data = rx_word;
  assign fifo_bus.rd_en   = rd_strobe;

  // Divider, PCS enables and exported clocks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      half_q          <= 1'b0;
      pcs_clk_en_q    <= 1'b0;
      fifo_wr_en_q    <= 1'b0;
      rx_clk_out_q    <= CLK_OUT_RST;
      recov_clk_tap_q <= CLK_OUT_RST;
      tx_clk_out_q    <= CLK_OUT_RST;
    end else begin
      if (recov_clk_en)
        half_q <= !half_q;
      pcs_clk_en_q <= recov_clk_en;
      fifo_wr_en_q <= wr_strobe;
      if (recov_clk_en)
        rx_clk_out_q <= !rx_clk_out_q;
      if (recov_clk_en && gigabit_ethernet_mode)
        recov_clk_tap_q <= !recov_clk_tap_q;
      else if (!gigabit_ethernet_mode)
        recov_clk_tap_q <= 1'b0;
      if (tx_clk_en)
        tx_clk_out_q <= !tx_clk_out_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFO read data and error flag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_q       <= '0;
      rx_data_valid_q <= 1'b0;
      fifo_error_q    <= 1'b0;
    end else begin
      rx_data_valid_q <= rd_strobe && !fifo_bus.empty;
      if (rd_strobe && !fifo_bus.empty)
        rx_data_q <= fifo_bus.rd_data;
      if (err_sample)
        fifo_error_q <= fifo_bus.full
                        || fifo_bus.empty;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Lock mode decode and clock-recovery state
  lock_mode_type  mode;
  lock_state_type state_q;
  lock_state_type state_d;
  logic [$clog2(REF_SETTLE_CYC+1)-1:0] settle_q;
  logic           settled;

  // Data-lock bit overrides the reference bit
  assign mode = force_data_lock ? mode_manual_data
              : force_ref_lock  ? mode_manual_ref : mode_auto;
  assign settled = (settle_q == $bits(settle_q)'(REF_SETTLE_CYC));

  // Next lock state
  always_comb begin
    state_d = state_q;
    case (mode)
      mode_manual_data: state_d = lock_to_data_state;
      mode_manual_ref:  state_d = lock_to_reference_state;
      mode_auto: begin
        case (state_q)
          lock_to_reference_state:
            if (settled && above_threshold)
              state_d = lock_to_data_state;
          lock_to_data_state:
            if (!above_threshold)
              state_d = lock_to_reference_state;
          default: state_d = lock_to_reference_state;
        endcase
      end
      default: state_d = lock_to_reference_state;
    endcase
  end

  // State, settle counter and lock output
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= lock_to_reference_state;
      settle_q    <= '0;
      data_lock_q <= DATA_LOCK_RST;
    end else begin
      state_q <= state_d;
      if (!ref_freq_near || state_q != lock_to_reference_state)
        settle_q <= '0;
      else if (!settled)
        settle_q <= settle_q + 1'b1;
      data_lock_q <= (state_d == lock_to_data_state);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slip count and signal presence
  logic sig_allowed;
  assign sig_allowed = pcie_mode || basic_8b10b_mode;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slip_count_out   <= SLIP_RST;
      signal_present_q <= 1'b0;
    end else begin
      if (!manual_align)
        slip_count_out <= SLIP_RST;
      else if (aligner_slip)
        slip_count_out <= (slip_count_out == 5'(WORD_BITS-1)) ? SLIP_RST
                          : slip_count_out + 5'h01;
      signal_present_q <= sig_allowed && above_threshold;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  pcs_enable_a: assert property (
    pcs_clk_en_q == $past(recov_clk_en))
    else $error("PCS enable does not follow recovered clock");
  write_half_a: assert property (
    (byte_deser_on && recov_clk_en) ##1 (byte_deser_on && recov_clk_en)
    |=> fifo_wr_en_q != $past(fifo_wr_en_q))
    else $error("FIFO write not halved");
  clk_export_a: assert property (
    recov_clk_en |=> rx_clk_out_q != $past(rx_clk_out_q))
    else $error("Recovered clock not exported");
  read_source_a: assert property (
    fabric_rd_clk_used && !fabric_rd_clk_en |=> !rx_data_valid_q)
    else $error("Read without fabric clock");
  fifo_error_a: assert property (
    err_sample && fifo_bus.empty |=> fifo_error_q)
    else $error("Empty FIFO not flagged");
  force_data_a: assert property (
    force_data_lock |-> ##1 data_lock_q)
    else $error("Forced data lock ignored");
  force_ref_a: assert property (
    !force_data_lock && force_ref_lock |=> !data_lock_q)
    else $error("Forced reference lock ignored");
  slip_clear_a: assert property (
    !manual_align |=> slip_count_out == SLIP_RST)
    else $error("Slip count not cleared");
  sig_gate_a: assert property (
    !pcie_mode && !basic_8b10b_mode |=> !signal_present_q)
    else $error("Signal present outside allowed modes");
  tap_gate_a: assert property (
    !gigabit_ethernet_mode |=> !recov_clk_tap_q)
    else $error("Clock tap outside Ethernet mode");
  tx_clock_a: assert property (
    tx_clk_en |=> tx_clk_out_q != $past(tx_clk_out_q))
    else $error("Transmit clock not toggled");

  auto_lock_c: cover property (
    mode == mode_auto && state_q == lock_to_reference_state ##1
    state_q == lock_to_data_state);
  fifo_full_c: cover property (fifo_bus.full);
  // Transmit clocking exercised without the rate match FIFO
  no_match_c:  cover property (!rate_match_on && tx_clk_en);
  slip_wrap_c: cover property (
    slip_count_out == 5'(WORD_BITS-1) ##1 slip_count_out == SLIP_RST);
  deser_c:     cover property (byte_deser_on && fifo_wr_en_q);
endmodule // rx_cdr_lock_and_clocking
`default_nettype wire

// >>> rx_clk_pkg.sv
// Shared constants and types for the receive clocking and lock control.
// Assumes one system clock; slower rates arrive as one-cycle enables.
package rx_clk_pkg;

  // Clock-recovery lock states
  typedef enum {
    lock_to_reference_state,
    lock_to_data_state
  } lock_state_type;

  // Lock mode selected by {force_data_lock, force_ref_lock}
  typedef enum {
    mode_auto,
    mode_manual_ref,
    mode_manual_data
  } lock_mode_type;

  // Reset values
  localparam logic       DATA_LOCK_RST  = 1'b0;
  localparam logic       CLK_OUT_RST    = 1'b0;
  localparam logic [4:0] SLIP_RST       = 5'h00;

  // Reference-lock qualification time in automatic mode
  localparam int         REF_SETTLE_NS  = 2000;
  localparam int         CLK_PERIOD_NS  = 40;
  localparam int         REF_SETTLE_CYC =
    (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default phase FIFO depth and data width
  localparam int         FIFO_DEPTH     = 8;
  localparam int         FIFO_WIDTH     = 10;

endpackage

// >>> phase_fifo_if.sv
// Interface joining the control logic and the phase compensation FIFO.
// Assumes both ends share sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface phase_fifo_if #(parameter int WIDTH = 10);
  logic             wr_en;
  logic [WIDTH-1:0] wr_data;
  logic             rd_en;
  logic [WIDTH-1:0] rd_data;
  logic             full;
  logic             empty;

  modport ctrl (output wr_en, output wr_data, output rd_en,
                input rd_data, input full, input empty);
  modport fifo (input wr_en, input wr_data, input rd_en,
                output rd_data, output full, output empty);
endinterface
`default_nettype wire

// >>> phase_fifo.sv
// Receive phase compensation FIFO storage with honest full and empty.
// Assumes writes and reads are one-cycle enables on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module phase_fifo
  import rx_clk_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int WIDTH = FIFO_WIDTH
) (
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  phase_fifo_if.fifo port_if
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      count_q;
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic             do_wr;
  logic             do_rd;

  // Accept only when room or data exists
  assign do_wr = port_if.wr_en && !port_if.full;
  assign do_rd = port_if.rd_en && !port_if.empty;
  assign port_if.full    = (count_q == (AW+1)'(DEPTH));
  assign port_if.empty   = (count_q == '0);
  assign port_if.rd_data = mem_q[rd_ptr_q];

  //////////////////////////////////////////////////////////////////////////
  // Pointers and occupancy
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_wr)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      if (do_rd)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Storage array
  always_ff @(posedge sys_clk) begin
    if (do_wr)
      mem_q[wr_ptr_q] <= port_if.wr_data;
  end
endmodule // phase_fifo
`default_nettype wire

// >>> fabric_user_model.sv
// Fabric-side user logic: read clock source and status synchroniser.
// Assumes it shares sys_clk with the block; reads run while rd_run is high.
`timescale 1ns/10ps
`default_nettype none
module fabric_user_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       rd_run,
  input  wire logic       data_lock_q,
  input  wire logic       signal_present_q,
  input  wire logic [4:0] slip_count_out,
  output logic            fabric_rd_clk_en,
  output logic            lock_sync,
  output logic            sig_sync,
  output logic [4:0]      slip_sync
);
  logic [6:0] meta_q;
  logic       div_q;
  // Half-rate read clock enable, stands still when not reading
  assign fabric_rd_clk_en = rd_run & div_q;
  //////////////////////////////////////////////////////////////////////
  // Two flops before any asynchronous status is used
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 1'b0;
      meta_q <= 7'h00;
      {lock_sync, sig_sync, slip_sync} <= 7'h00;
    end else begin
      div_q <= ~div_q;
      meta_q <= {data_lock_q, signal_present_q, slip_count_out};
      {lock_sync, sig_sync, slip_sync} <= meta_q;
    end
  end
endmodule // fabric_user_model
`default_nettype wire

// >>> rx_cdr_lock_and_clocking_tb_top.sv
// Self-checking bench for the receive clocking and lock control.
// Assumes the package, interface, design and fabric model compile first.
`timescale 1ns/10ps
`default_nettype none
module rx_cdr_lock_and_clocking_tb_top;
  import rx_clk_pkg::*;
  logic sys_clk, reset_n, recov_clk_en, tx_clk_en, core_clk_en, rd_run;
  logic fabric_rd_clk_used, rate_match_on;
  logic bonded, byte_deser_on, force_data_lock, force_ref_lock;
  logic ref_freq_near, manual_align, aligner_slip, above_threshold;
  logic pcie_mode, basic_8b10b_mode, gigabit_ethernet_mode;
  logic fabric_rd_clk_en, pcs_clk_en_q, fifo_wr_en_q, rx_clk_out_q;
  logic recov_clk_tap_q, tx_clk_out_q, rx_data_valid_q, fifo_error_q;
  logic data_lock_q, signal_present_q, lock_sync, sig_sync, old;
  logic [9:0] rx_word, rx_data_q, last_q;
  logic [4:0] slip_count_out, slip_sync;
  int         err_count, num_checks, n_wr, n_pcs, n_vld, n_tap;
  rx_cdr_lock_and_clocking i_rx_cdr_lock_and_clocking (
    .sys_clk, .reset_n, .recov_clk_en, .tx_clk_en, .core_clk_en,
    .fabric_rd_clk_en, .fabric_rd_clk_used, .bonded, .byte_deser_on,
    .rate_match_on, .rx_word, .force_data_lock, .force_ref_lock,
    .ref_freq_near, .manual_align, .aligner_slip, .above_threshold,
    .pcie_mode, .basic_8b10b_mode, .gigabit_ethernet_mode, .pcs_clk_en_q,
    .fifo_wr_en_q, .rx_clk_out_q, .recov_clk_tap_q, .tx_clk_out_q,
    .rx_data_q, .rx_data_valid_q, .fifo_error_q, .data_lock_q,
    .slip_count_out, .signal_present_q);
  fabric_user_model i_fabric_user_model (
    .sys_clk, .reset_n, .rd_run, .data_lock_q, .signal_present_q,
    .slip_count_out, .fabric_rd_clk_en, .lock_sync, .sig_sync, .slip_sync);
  //////////////////////////////////////////////////////////////////////
  // Clock and event counters
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (fifo_wr_en_q === 1'b1) n_wr++;
    if (pcs_clk_en_q === 1'b1) n_pcs++;
    if (recov_clk_tap_q === 1'b1) n_tap++;
    if (rx_data_valid_q === 1'b1) begin
      n_vld++;
      last_q = rx_data_q;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Compare, wait and pulse helpers
  task automatic chk_b(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_v(logic [9:0] got, logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1'b1;
    @(negedge sys_clk) s = 1'b0;
    cyc(1);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_fifo;
    bonded = 1'b1;
    pulse(core_clk_en);
    chk_b(fifo_error_q, 1'b1);
    rx_word = 10'h001;
    pulse(recov_clk_en);
    pulse(tx_clk_en);
    chk_b(fifo_error_q, 1'b1);
    pulse(core_clk_en);
    chk_b(fifo_error_q, 1'b0);
    bonded = 1'b0;
    for (int i = 2; i <= 9; i++) begin
      rx_word = 10'(i);
      pulse(recov_clk_en);
    end
    pulse(tx_clk_en);
    chk_b(fifo_error_q, 1'b1);
    n_vld = 0;
    rd_run = 1'b1;
    cyc(30);
    rd_run = 1'b0;
    chk_v(10'(n_vld), 10'h008);
    chk_v(last_q, 10'h008);
    // Without the fabric clock the recovered rate reads the FIFO
    fabric_rd_clk_used = 1'b0;
    n_vld = 0;
    rx_word = 10'h155;
    repeat (2) pulse(recov_clk_en);
    fabric_rd_clk_used = 1'b1;
    chk_v(10'(n_vld), 10'h001);
    chk_v(last_q, 10'h155);
  endtask
  task automatic test_clocks;
    rd_run = 1'b1;
    {n_wr, n_pcs, n_tap} = '0;
    old = rx_clk_out_q;
    repeat (3) pulse(recov_clk_en);
    chk_v(10'(n_pcs), 10'h003);
    chk_v(10'(n_wr), 10'h003);
    chk_b(rx_clk_out_q, ~old);
    chk_v(10'(n_tap), 10'h000);
    gigabit_ethernet_mode = 1'b1;
    repeat (2) pulse(recov_clk_en);
    chk_b(n_tap != 0, 1'b1);
    byte_deser_on = 1'b1;
    n_wr = 0;
    repeat (4) pulse(recov_clk_en);
    chk_v(10'(n_wr), 10'h002);
    n_wr = 0;
    recov_clk_en = 1'b1;
    cyc(4);
    recov_clk_en = 1'b0;
    cyc(2);
    chk_v(10'(n_wr), 10'h002);
    byte_deser_on = 1'b0;
    rate_match_on = 1'b0;
    old = tx_clk_out_q;
    pulse(tx_clk_en);
    chk_b(tx_clk_out_q, ~old);
    old = rx_clk_out_q;
    pulse(recov_clk_en);
    chk_b(rx_clk_out_q, ~old);
    rate_match_on = 1'b1;
    rd_run = 1'b0;
  endtask
  task automatic test_lock;
    logic [1:0] m [4] = '{2'b10, 2'b01, 2'b11, 2'b01};
    for (int i = 0; i < 4; i++) begin
      {force_data_lock, force_ref_lock} = m[i];
      cyc(2);
      chk_b(data_lock_q, m[i][1]);
    end
    {force_data_lock, force_ref_lock, ref_freq_near, above_threshold} = 4'h3;
    cyc(REF_SETTLE_CYC - 10);
    chk_b(data_lock_q, 1'b0);
    cyc(20);
    chk_b(data_lock_q, 1'b1);
    cyc(3);
    chk_b(lock_sync, 1'b1);
    {ref_freq_near, above_threshold} = 2'h0;
    cyc(2);
    chk_b(data_lock_q, 1'b0);
  endtask
  task automatic test_signal;
    above_threshold = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {pcie_mode, basic_8b10b_mode} = 2'(i);
      cyc(2);
      chk_b(signal_present_q, 1'(i != 0));
    end
    above_threshold = 1'b0;
    cyc(5);
    chk_b(sig_sync, 1'b0);
  endtask
  task automatic test_slip;
    manual_align = 1'b1;
    repeat (3) pulse(aligner_slip);
    chk_v(10'(slip_count_out), 10'h003);
    repeat (7) pulse(aligner_slip);
    chk_v(10'(slip_count_out), 10'h000);
    pulse(aligner_slip);
    cyc(2);
    chk_v(10'(slip_sync), 10'h001);
    manual_align = 1'b0;
    cyc(2);
    chk_v(10'(slip_count_out), 10'h000);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    {reset_n, recov_clk_en, tx_clk_en, core_clk_en, rd_run, bonded} = '0;
    {byte_deser_on, force_data_lock, force_ref_lock, ref_freq_near} = '0;
    {manual_align, aligner_slip, above_threshold, pcie_mode} = '0;
    {basic_8b10b_mode, gigabit_ethernet_mode, rx_word} = '0;
    {fabric_rd_clk_used, rate_match_on} = 2'h3;
    cyc(2);
    chk_v({data_lock_q, rx_clk_out_q, tx_clk_out_q, slip_count_out}, '0);
    reset_n = 1'b1;
    cyc(1);
    test_fifo();
    test_clocks();
    test_lock();
    test_signal();
    test_slip();
    test_done();
  end
  initial begin
    #(CLK_PERIOD_NS * 5000);
    err_count++;
    test_done();
  end
endmodule // rx_cdr_lock_and_clocking_tb_top
`default_nettype wire
